// File: hw/slm_pkg.sv
// ====================================================================
// Shared constants and types for the supply level monitor registers
// ====================================================================
package slm_pkg;

    // ================================================================
    // Register indices (byte address is four times the index)
    // ================================================================
    localparam logic [7:0] SLM_IDX_THRESHOLD_CTRL = 8'h08;
    localparam logic [7:0] SLM_IDX_IRQ_CTRL = 8'h09;
    localparam logic [7:0] SLM_IDX_IRQ_FLAGS = 8'h0A;
    localparam logic [7:0] SLM_IDX_LEVEL_STATUS = 8'h0B;

    // Bit bounds of the word-index slice taken from haddr
    localparam int unsigned SLM_IDX_LSB = 2;
    localparam int unsigned SLM_IDX_MSB = 9;

    // ================================================================
    // Field positions
    // ================================================================
    localparam int unsigned SLM_THR_SEL_LSB = 0;
    localparam int unsigned SLM_IRQ_EN_BIT = 0;
    localparam int unsigned SLM_TRIG_SEL_LSB = 1;
    localparam int unsigned SLM_FLAG_BIT = 0;
    localparam int unsigned SLM_STATUS_BIT = 0;

    // ================================================================
    // Reset values
    // ================================================================
    localparam logic [7:0] SLM_THRESHOLD_CTRL_RST = 8'h00;
    localparam logic [7:0] SLM_IRQ_CTRL_RST = 8'h00;
    localparam logic [7:0] SLM_IRQ_FLAGS_RST = 8'h00;
    localparam logic [7:0] SLM_LEVEL_STATUS_RST = 8'h00;

    // ================================================================
    // Bus constants
    // ================================================================
    localparam logic [1:0] SLM_HTRANS_IDLE = 2'h0;
    localparam logic [1:0] SLM_HTRANS_NONSEQ = 2'h2;
    localparam logic SLM_HRESP_OKAY = 1'b0;

    // Threshold offset above the brown-out level
    typedef enum logic [1:0] {
        SLM_THR_5PCT = 2'h0,
        SLM_THR_15PCT = 2'h1,
        SLM_THR_25PCT = 2'h2,
        SLM_THR_RSVD = 2'h3
    } slm_thr_e;

    // Event that raises the monitor flag
    typedef enum logic [1:0] {
        SLM_TRIG_BELOW = 2'h0,
        SLM_TRIG_ABOVE = 2'h1,
        SLM_TRIG_CROSS = 2'h2,
        SLM_TRIG_RSVD = 2'h3
    } slm_trig_e;

    // Interrupt control register contents
    typedef struct packed {
        slm_trig_e trig_sel;
        logic irq_en;
    } slm_irq_ctrl_s;

    // AHB-Lite address phase as seen by the slave
    typedef struct packed {
        logic hsel;
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
    } slm_ahb_req_s;

endpackage

// File: hw/slm_sync2.sv
`timescale 1ns/1ps
// ====================================================================
// Two-flop synchroniser for levels arriving from outside the clock
// ====================================================================
module slm_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level in and synchronised level out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // First stage; only the second stage looks at it
    logic [WIDTH-1:0] meta_r;

    // Two stages in series to settle metastability
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule

// File: hw/slm_evt_det.sv
`timescale 1ns/1ps
// ====================================================================
// Threshold crossing detector for the synchronised comparator level
// ====================================================================
module slm_evt_det (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Synchronised below-threshold level and selected event
    input wire logic below,
    input wire slm_pkg::slm_trig_e trig_sel,
    // One-cycle pulse when the selected event occurs
    output logic event_hit
);
    import slm_pkg::*;

    // Level seen one cycle earlier
    logic prev_r;
    // Individual crossings
    logic fall_below;
    logic rise_above;

    // Track the level always, so enabling later gives no false edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev_r <= 1'b0;
        end
        else
        begin
            prev_r <= below;
        end
    end

    assign fall_below = below & ~prev_r;
    assign rise_above = ~below & prev_r;

    // Pick the crossing; the reserved code never fires
    always_comb
    begin
        case (trig_sel)
            SLM_TRIG_BELOW: event_hit = fall_below;
            SLM_TRIG_ABOVE: event_hit = rise_above;
            SLM_TRIG_CROSS: event_hit = fall_below | rise_above;
            default: event_hit = 1'b0;
        endcase
    end

endmodule

// File: hw/slm_regs.sv
`timescale 1ns/1ps
module slm_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire slm_pkg::slm_ahb_req_s ahb_req,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Comparator result, asynchronous, high while supply is below
    input wire logic cmp_below,
    // Brown-out detector state and debug halt, same clock domain
    input wire logic bod_enabled,
    input wire logic dbg_halted,
    // Threshold select to the analog comparator
    output slm_pkg::slm_thr_e monitor_threshold_select,
    // Level interrupt request
    output logic irq
);
    import slm_pkg::*;

    // ================================================================
    // Declarations
    // ================================================================
    // Synchronised comparator level
    logic below_s;
    // Selected crossing seen this cycle
    logic event_hit;
    // Interrupt control register
    slm_irq_ctrl_s irq_ctrl_r;
    // Monitor flag and its next value
    logic monitor_irq_flag_r;
    logic monitor_irq_flag_nxt;
    // Address phase decode
    logic addr_acc;
    logic addr_map;
    logic [7:0] addr_idx;
    // Data phase state latched from the address phase
    logic dp_wr_r;
    logic dp_map_r;
    logic [7:0] dp_idx_r;
    // Read held back one cycle behind a write data phase
    logic rd_late_r;
    logic rd_late_map_r;
    logic [7:0] rd_late_idx_r;
    // Read mux select and result
    logic rd_map;
    logic [7:0] rd_idx;
    logic [31:0] rd_word;
    // Write strobes in the data phase
    logic wr_thr;
    logic wr_ctrl;
    logic wr_flags;
    // Flag set and clear terms
    logic flag_set;
    logic flag_clr;

    // ================================================================
    // Input synchroniser and event detector
    // ================================================================
    // Comparator output is analog-derived, so it is settled first
    slm_sync2 #(
        .WIDTH(1)
    ) u_sync_below (
        .clk(clk),
        .rst(rst),
        .d(cmp_below),
        .q(below_s)
    );

    slm_evt_det u_evt_det (
        .clk(clk),
        .rst(rst),
        .below(below_s),
        .trig_sel(irq_ctrl_r.trig_sel),
        .event_hit(event_hit)
    );

    // ================================================================
    // AHB-Lite address phase decode
    // ================================================================
    // Only NONSEQ is expected; SEQ is taken the same way
    assign addr_acc = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
    assign addr_idx = ahb_req.haddr[SLM_IDX_MSB:SLM_IDX_LSB];
    // Unmapped words read zero and ignore writes
    always_comb
    begin
        addr_map = 1'b0;
        if (ahb_req.haddr[31:SLM_IDX_MSB+1] != '0)
        begin
            addr_map = 1'b0;
        end
        else if ((addr_idx >= SLM_IDX_THRESHOLD_CTRL) && (addr_idx <= SLM_IDX_LEVEL_STATUS))
        begin
            // The four registers occupy consecutive words
            addr_map = 1'b1;
        end
    end

    // Latch the write address phase for its data phase
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dp_wr_r <= 1'b0;
            dp_map_r <= 1'b0;
            dp_idx_r <= 8'h00;
        end
        else
        begin
            dp_wr_r <= addr_acc & ahb_req.hwrite;
            dp_map_r <= addr_map;
            dp_idx_r <= addr_idx;
        end
    end

    // Write strobes; hwdata is valid in the data phase
    assign wr_thr = dp_wr_r & dp_map_r & (dp_idx_r == SLM_IDX_THRESHOLD_CTRL);
    assign wr_ctrl = dp_wr_r & dp_map_r & (dp_idx_r == SLM_IDX_IRQ_CTRL);
    assign wr_flags = dp_wr_r & dp_map_r & (dp_idx_r == SLM_IDX_IRQ_FLAGS);

    // ================================================================
    // Read path
    // ================================================================
    // A read right behind a write waits one cycle so it sees the write
    assign rd_idx = rd_late_r ? rd_late_idx_r : addr_idx;
    assign rd_map = rd_late_r ? rd_late_map_r : addr_map;

    // Register read mux; unused bits read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (!rd_map)
        begin
            rd_word = 32'h0000_0000;
        end
        else if (rd_idx == SLM_IDX_THRESHOLD_CTRL)
        begin
            rd_word[SLM_THR_SEL_LSB+:2] = monitor_threshold_select;
        end
        else if (rd_idx == SLM_IDX_IRQ_CTRL)
        begin
            rd_word[SLM_IRQ_EN_BIT] = irq_ctrl_r.irq_en;
            rd_word[SLM_TRIG_SEL_LSB+:2] = irq_ctrl_r.trig_sel;
        end
        else if (rd_idx == SLM_IDX_IRQ_FLAGS)
        begin
            rd_word[SLM_FLAG_BIT] = monitor_irq_flag_r;
        end
        else if (rd_idx == SLM_IDX_LEVEL_STATUS)
        begin
            // live level, no stored copy to write
            rd_word[SLM_STATUS_BIT] = below_s;
        end
    end

    // Read data, ready and response registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= SLM_HRESP_OKAY;
            rd_late_r <= 1'b0;
            rd_late_map_r <= 1'b0;
            rd_late_idx_r <= 8'h00;
        end
        else
        begin
            hresp <= SLM_HRESP_OKAY;
            rd_late_r <= 1'b0;
            hreadyout <= 1'b1;
            if (rd_late_r)
            begin
                hrdata <= rd_word;
            end
            else if (addr_acc && !ahb_req.hwrite && dp_wr_r)
            begin
                // Stall the read data phase one cycle
                rd_late_r <= 1'b1;
                rd_late_map_r <= addr_map;
                rd_late_idx_r <= addr_idx;
                hreadyout <= 1'b0;
            end
            else if (addr_acc && !ahb_req.hwrite)
            begin
                hrdata <= rd_word;
            end
        end
    end

    // ================================================================
    // Control registers
    // ================================================================
    // threshold code drives the comparator; reserved code is kept
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            monitor_threshold_select <= slm_thr_e'(SLM_THRESHOLD_CTRL_RST[1:0]);
        end
        else if (wr_thr)
        begin
            monitor_threshold_select <= slm_thr_e'(hwdata[SLM_THR_SEL_LSB+:2]);
        end
    end

    // Interrupt enable and trigger select
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_ctrl_r <= slm_irq_ctrl_s'(SLM_IRQ_CTRL_RST[2:0]);
        end
        else if (wr_ctrl)
        begin
            irq_ctrl_r.irq_en <= hwdata[SLM_IRQ_EN_BIT];
            irq_ctrl_r.trig_sel <= slm_trig_e'(hwdata[SLM_TRIG_SEL_LSB+:2]);
        end
    end

    // ================================================================
    // Monitor flag
    // ================================================================
    // hardware sets only while the detector runs
    assign flag_set = event_hit & bod_enabled;
    assign flag_clr = wr_flags & hwdata[SLM_FLAG_BIT];

    // clear first, then a set in the same cycle wins
    always_comb
    begin
        monitor_irq_flag_nxt = monitor_irq_flag_r;
        if (flag_clr)
        begin
            monitor_irq_flag_nxt = 1'b0;
        end
        if (flag_set)
        begin
            monitor_irq_flag_nxt = 1'b1;
        end
    end

    // Sticky flag register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            monitor_irq_flag_r <= SLM_IRQ_FLAGS_RST[SLM_FLAG_BIT];
        end
        else
        begin
            monitor_irq_flag_r <= monitor_irq_flag_nxt;
        end
    end

    // ================================================================
    // Interrupt output
    // ================================================================
    // level request, gated enable and debug halt
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= irq_ctrl_r.irq_en & monitor_irq_flag_r & ~dbg_halted;
        end
    end

    // ================================================================
    // Assertions
    // ================================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Building blocks for the flag sequences
    sequence seq_sw_clear;
        flag_clr;
    endsequence
    sequence seq_fall_below;
        $rose(below_s) && bod_enabled;
    endsequence

    AST_THR_WRITE: assert property (wr_thr |=> monitor_threshold_select == $past(hwdata[1:0]))
        else $error("threshold select did not take the written code");
    AST_BELOW_SETS: assert property (
        (irq_ctrl_r.trig_sel == SLM_TRIG_BELOW) and seq_fall_below |=> monitor_irq_flag_r)
        else $error("drop below threshold did not set the flag");
    AST_RSVD_TRIG: assert property (
        (irq_ctrl_r.trig_sel == SLM_TRIG_RSVD) && !monitor_irq_flag_r |=> !monitor_irq_flag_r)
        else $error("reserved trigger code set the flag");
    AST_ABOVE_SETS: assert property (
        (irq_ctrl_r.trig_sel == SLM_TRIG_ABOVE) && $fell(below_s) && bod_enabled
        |=> monitor_irq_flag_r)
        else $error("rise above threshold did not set the flag");
    AST_EN_OFF: assert property (!irq_ctrl_r.irq_en |=> !irq)
        else $error("interrupt raised while disabled");
    AST_HOLD_DIS: assert property (!bod_enabled && !flag_clr |=> $stable(monitor_irq_flag_r))
        else $error("flag changed while detector disabled");
    AST_STATUS_RD: assert property (
        addr_acc && !ahb_req.hwrite && !dp_wr_r && addr_map
        && (addr_idx == SLM_IDX_LEVEL_STATUS)
        |=> hrdata == {31'h0000_0000, $past(below_s)})
        else $error("status read did not show the live level");
    AST_IRQ_ON: assert property (
        irq_ctrl_r.irq_en && monitor_irq_flag_r && !dbg_halted |=> irq ##1 (irq || !monitor_irq_flag_r
        || !irq_ctrl_r.irq_en || dbg_halted || $past(dbg_halted)))
        else $error("request missing while enabled and flagged");
    AST_DBG_BLOCK: assert property (dbg_halted |=> !irq)
        else $error("interrupt raised during debug halt");
    AST_W1C: assert property (seq_sw_clear and !flag_set |=> !monitor_irq_flag_r)
        else $error("write one did not clear the flag");
    AST_SET_WINS: assert property (seq_sw_clear and flag_set |=> monitor_irq_flag_r)
        else $error("event lost against a simultaneous clear");

endmodule

// File: testbench/test_slm_regs.sv
`timescale 1ns/1ps
// ====================================================================
// Shared comparison: counts every check and reports each mismatch
// ====================================================================
`define CHK(nm, ex, ac) begin tests_run++; if ((ac) !== (ex)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, ac); end end

module test_slm_regs;
    import slm_pkg::*;

    // ================================================================
    // Byte addresses, four times the register index
    // ================================================================
    localparam logic [31:0] A_THR = {22'h0, SLM_IDX_THRESHOLD_CTRL, 2'h0};
    localparam logic [31:0] A_CTL = {22'h0, SLM_IDX_IRQ_CTRL, 2'h0};
    localparam logic [31:0] A_FLG = {22'h0, SLM_IDX_IRQ_FLAGS, 2'h0};
    localparam logic [31:0] A_STS = {22'h0, SLM_IDX_LEVEL_STATUS, 2'h0};
    // Unused word inside the decoded range
    localparam logic [31:0] A_NONE = 32'h0000_0040;

    // Clock, reset and bus master signals
    logic clk;
    logic rst;
    logic m_sel;
    logic [1:0] m_trans;
    logic [31:0] m_addr;
    logic m_wr;
    logic [2:0] m_size;
    logic [31:0] hwdata;
    slm_ahb_req_s ahb_req;
    // Design outputs
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    slm_thr_e thr_sel;
    logic irq;
    // Analog side and system state
    logic cmp_below;
    logic bod_enabled;
    logic dbg_halted;
    // Bookkeeping
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed;
    logic [31:0] rd;
    logic [31:0] v;
    // Reference model state kept as plain integers
    int e_ien, e_trig, e_flag, e_below;

    // Single slave, so its ready is the bus ready
    assign ahb_req = {m_sel, m_trans, m_addr, m_wr, m_size, hreadyout};

    slm_regs i_slm_regs (
        .clk(clk),
        .rst(rst),
        .ahb_req(ahb_req),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .cmp_below(cmp_below),
        .bod_enabled(bod_enabled),
        .dbg_halted(dbg_halted),
        .monitor_threshold_select(thr_sel),
        .irq(irq)
    );

    // ================================================================
    // Clock and hang guard
    // ================================================================
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // The whole run needs a few hundred cycles; far beyond that is a hang
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end

    // Verdict and end of run
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ================================================================
    // Bus master tasks
    // ================================================================
    // Samples ready and data at the rising edge, before the slave's update lands
    task automatic wait_rdy(output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        q = hrdata;
        `CHK("hresp", SLM_HRESP_OKAY, hresp)
        if (n >= 50)
            `CHK("hreadyout", 1'b1, hreadyout)
    endtask

    // One single transfer; entered just after a rising edge
    task automatic ahb(input logic wr_en, input logic [31:0] a, input logic [31:0] d);
        m_sel <= 1'b1;
        m_trans <= SLM_HTRANS_NONSEQ;
        m_addr <= a;
        m_wr <= wr_en;
        m_size <= 3'h2;
        wait_rdy(rd);
        m_sel <= 1'b0;
        m_trans <= SLM_HTRANS_IDLE;
        hwdata <= wr_en ? d : 32'h0;
        wait_rdy(rd);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rdchk(input string nm, input logic [31:0] a, input int ex);
        ahb(1'b0, a, 32'h0);
        `CHK(nm, 32'(ex), rd)
    endtask

    // ================================================================
    // Model updates and comparisons
    // ================================================================
    task automatic set_ctl(input int ien, input int trig);
        wr(A_CTL, 32'((trig << 1) | ien));
        e_ien = ien;
        e_trig = trig;
    endtask

    task automatic clr_flag;
        wr(A_FLG, 32'h0000_0001);
        e_flag = 0;
    endtask

    // Level change; the edge tracker follows it even while disabled
    task automatic set_cmp(input int lvl);
        if (bod_enabled === 1'b1 && lvl != e_below)
        begin
            if ((e_trig == 0 && lvl == 1) || (e_trig == 1 && lvl == 0) || e_trig == 2)
                e_flag = 1;
        end
        e_below = lvl;
        cmp_below <= 1'(lvl);
        repeat (6) @(posedge clk);
    endtask

    task automatic chk_state;
        rdchk("flag", A_FLG, e_flag);
        rdchk("status", A_STS, e_below);
        `CHK("irq", 1'(e_flag & e_ien & ~int'(dbg_halted)), irq)
    endtask

    // ================================================================
    // Main sequence
    // ================================================================
    initial
    begin
        seed = 32'h517DBD0A;
        rst = 1'b1;
        m_sel = 1'b0;
        m_trans = SLM_HTRANS_IDLE;
        m_addr = 32'h0;
        m_wr = 1'b0;
        m_size = 3'h2;
        hwdata = 32'h0;
        cmp_below = 1'b0;
        bod_enabled = 1'b1;
        dbg_halted = 1'b0;
        e_ien = 0;
        e_trig = 0;
        e_flag = 0;
        e_below = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);

        // Every register starts at zero
        rdchk("thr rst", A_THR, 0);
        rdchk("ctl rst", A_CTL, 0);
        chk_state();
        $display("Test reset values done");

        // Every threshold code, with the unused upper bits set
        for (int c = 0; c < 4; c++)
        begin
            wr(A_THR, 32'hFFFF_FFFC | 32'(c));
            rdchk("thr", A_THR, c);
            `CHK("thr out", 2'(c), thr_sel)
        end
        repeat (4)
        begin
            v = $random(seed);
            wr(A_THR, v);
            rdchk("thr rnd", A_THR, int'(v[1:0]));
        end
        // Unmapped word and the read-only status ignore writes
        wr(A_NONE, 32'hFFFF_FFFF);
        rdchk("unmapped", A_NONE, 0);
        rdchk("thr kept", A_THR, int'(v[1:0]));
        wr(A_STS, 32'h0000_0001);
        rdchk("status ro", A_STS, 0);
        $display("Test threshold and decode done");

        // Every trigger code against a drop and a rise
        for (int t = 0; t < 4; t++)
        begin
            set_ctl(1, t);
            rdchk("ctl", A_CTL, (t << 1) | 1);
            set_cmp(1);
            chk_state();
            wr(A_FLG, 32'h0000_0000);
            chk_state();
            clr_flag();
            chk_state();
            set_cmp(0);
            chk_state();
            clr_flag();
        end
        $display("Test trigger codes done");

        // Flag frozen while the detector is off, either value
        bod_enabled <= 1'b0;
        @(posedge clk);
        set_ctl(1, 2);
        set_cmp(1);
        chk_state();
        bod_enabled <= 1'b1;
        @(posedge clk);
        set_cmp(0);
        chk_state();
        bod_enabled <= 1'b0;
        @(posedge clk);
        set_cmp(1);
        chk_state();
        bod_enabled <= 1'b1;
        @(posedge clk);
        $display("Test detector gating done");

        // Mask, debug halt and clear of a pending request
        set_ctl(0, 2);
        chk_state();
        set_ctl(1, 2);
        chk_state();
        dbg_halted <= 1'b1;
        repeat (3) @(posedge clk);
        chk_state();
        dbg_halted <= 1'b0;
        repeat (3) @(posedge clk);
        chk_state();
        clr_flag();
        chk_state();
        // Crossing lands on the edge that ends the clear's data phase
        cmp_below <= 1'b0;
        e_below = 0;
        e_flag = 1;
        @(posedge clk);
        wr(A_FLG, 32'h0000_0001);
        chk_state();
        $display("Test interrupt masking done");
        stop_test();
    end
endmodule
